/* File: core/rbmc_burst_ctrl.sv */
// Burst-mode gating for the PWM engine in resonant mode.
// Assumes synchronous register port and status inputs from the core.
`timescale 1ns/1ps
`default_nettype none
`include "rbmc_regs.svh"
module rbmc_burst_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Converter status
  input wire logic resonant_mode,
  input wire logic soft_start,
  input wire logic converter_on,
  input wire logic [7:0] freq_limit_max,
  input wire logic [7:0] switch_freq,
  // Outputs to PWM engine
  output logic burst_allowed,
  output logic burst_active,
  output logic [8:0] burst_threshold,
  output logic [7:0] third_pwm_output_fall_dt
);
  logic rst_q1;
  logic rst_n;
  logic [7:0] burst_cfg;
  logic [7:0] third_pwm_fall;
  logic [7:0] rd_data;
  rbmc_pkg::rbmc_en_t en_mode;
  rbmc_pkg::rbmc_state_t state;
  rbmc_pkg::rbmc_state_t next_state;
  logic next_allowed;
  logic [8:0] next_threshold;
  logic run_ok;
  logic soft_ok;
  logic next_active;
  logic [8:0] next_threshold_out;
  // ================================================================
  // Reset release
  // Assertion acts at once; release waits two edges so that no flop
  // leaves reset in a different cycle from its neighbours.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end
  // ================================================================
  // Registers
  // Writes land on the strobe edge; the store also serves reads
  rbmc_regfile u_regs (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .addr(reg_addr),
    .wr_en(reg_wr),
    .wr_data(reg_wdata),
    .rd_data(rd_data),
    .burst_cfg(burst_cfg),
    .third_pwm_fall(third_pwm_fall)
  );
  // ================================================================
  // Enable code
  assign en_mode = rbmc_pkg::rbmc_en_t'(burst_cfg[`RBMC_EN_HI:`RBMC_EN_LO]);
  // ================================================================
  // Operating phase tracking
  // Converter off always means idle; soft start and regulation may
  // follow one another in either order while the converter runs.
  always_comb begin
    next_state = state;
    case (state)
      rbmc_pkg::RBMC_ST_IDLE: begin
        if (converter_on) begin
          next_state = soft_start ? rbmc_pkg::RBMC_ST_SOFT
                                  : rbmc_pkg::RBMC_ST_RUN;
        end
      end
      rbmc_pkg::RBMC_ST_SOFT: begin
        if (!converter_on) begin
          next_state = rbmc_pkg::RBMC_ST_IDLE;
        end else if (!soft_start) begin
          next_state = rbmc_pkg::RBMC_ST_RUN;
        end
      end
      rbmc_pkg::RBMC_ST_RUN: begin
        if (!converter_on) begin
          next_state = rbmc_pkg::RBMC_ST_IDLE;
        end else if (soft_start) begin
          next_state = rbmc_pkg::RBMC_ST_SOFT;
        end
      end
      default: next_state = rbmc_pkg::RBMC_ST_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rbmc_pkg::RBMC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // ================================================================
  // Enable decode
  // Phase permissions from the two-bit enable code
  always_comb begin
    run_ok = 1'h0;
    soft_ok = 1'h0;
    case (en_mode)
      rbmc_pkg::RBMC_EN_OFF: begin
        run_ok = 1'h0;
        soft_ok = 1'h0;
      end
      rbmc_pkg::RBMC_EN_OFF_ALT: begin
        run_ok = 1'h0;
        soft_ok = 1'h0;
      end
      rbmc_pkg::RBMC_EN_NORMAL: begin
        run_ok = 1'h1;
        soft_ok = 1'h0;
      end
      rbmc_pkg::RBMC_EN_ALL: begin
        run_ok = 1'h1;
        soft_ok = 1'h1;
      end
      default: begin
        run_ok = 1'h0;
        soft_ok = 1'h0;
      end
    endcase
  end
  // ================================================================
  // Permission for the coming cycle
  // Judged on next_state so that permission and phase change together
  always_comb begin
    next_allowed = 1'h0;
    case (next_state)
      rbmc_pkg::RBMC_ST_RUN: next_allowed = run_ok;
      rbmc_pkg::RBMC_ST_SOFT: next_allowed = soft_ok;
      rbmc_pkg::RBMC_ST_IDLE: next_allowed = 1'h0;
      default: next_allowed = 1'h0;
    endcase
    // Settings have no meaning outside resonant mode
    if (!resonant_mode) begin
      next_allowed = 1'h0;
    end
  end
  // ================================================================
  // Threshold
  // Top frequency limit less the offset; an offset above the limit
  // wraps into the ninth bit, which no frequency code can reach.
  assign next_threshold = {1'h0, freq_limit_max}
    - {3'h0, burst_cfg[`RBMC_OFS_HI:`RBMC_OFS_LO]};
  // Outside resonant mode the offset is ignored and zero is shown
  always_comb begin
    next_threshold_out = 9'h000;
    if (resonant_mode) begin
      next_threshold_out = next_threshold;
    end
  end
  // Burst starts once the frequency reaches the threshold
  assign next_active = next_allowed
    && ({1'h0, switch_freq} >= next_threshold);
  // ================================================================
  // Permission output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_allowed <= 1'h0;
    end else begin
      burst_allowed <= next_allowed;
    end
  end
  // ================================================================
  // Burst activity output
  // No hysteresis: a frequency hovering at the threshold toggles
  // burst from cycle to cycle; the loop is expected to filter it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_active <= 1'h0;
    end else begin
      burst_active <= next_active;
    end
  end
  // ================================================================
  // Threshold output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_threshold <= 9'h000;
    end else begin
      burst_threshold <= next_threshold_out;
    end
  end
  // ================================================================
  // Register read output
  // Second register stage; reads take two edges after the address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_data;
    end
  end
  // ================================================================
  // Dead-time export
  // Stored only; the edge timing itself lives in the PWM engine
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      third_pwm_output_fall_dt <= 8'h00;
    end else begin
      third_pwm_output_fall_dt <= third_pwm_fall;
    end
  end
endmodule : rbmc_burst_ctrl
`default_nettype wire

/* File: inc/rbmc_regs.svh */
// Register offsets, field positions and reset values of the resonant
// burst-mode block. Assumes inclusion by bare name from design files.
`ifndef RBMC_REGS_SVH
`define RBMC_REGS_SVH
// ==================================================================
// Offsets
`define RBMC_BURST_CFG_ADDR 8'h4a
`define RBMC_THIRD_FALL_ADDR 8'h4b
// ==================================================================
// Fields
`define RBMC_EN_HI 7
`define RBMC_EN_LO 6
`define RBMC_OFS_HI 5
`define RBMC_OFS_LO 0
// ==================================================================
// Reset values
`define RBMC_BURST_CFG_RST 8'h00
`define RBMC_THIRD_FALL_RST 8'h00
`endif

/* File: inc/rbmc_pkg.sv */
// Types of the resonant burst-mode block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package rbmc_pkg;
  typedef enum logic [1:0] {
    RBMC_EN_OFF = 2'h0,
    RBMC_EN_NORMAL = 2'h1,
    RBMC_EN_OFF_ALT = 2'h2,
    RBMC_EN_ALL = 2'h3
  } rbmc_en_t;
  typedef enum logic [2:0] {
    RBMC_ST_IDLE = 3'h1,
    RBMC_ST_SOFT = 3'h2,
    RBMC_ST_RUN = 3'h4
  } rbmc_state_t;
endpackage : rbmc_pkg
`default_nettype wire

/* File: core/rbmc_regfile.sv */
// Byte-wide register store for the two registers at 0x4a and 0x4b.
// Assumes a synchronous single-cycle write strobe; read data registered.
`timescale 1ns/1ps
`default_nettype none
`include "rbmc_regs.svh"
module rbmc_regfile (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Access
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // Stored values
  output logic [7:0] burst_cfg,
  output logic [7:0] third_pwm_fall
);
  // ================================================================
  // Storage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_cfg <= `RBMC_BURST_CFG_RST;
      third_pwm_fall <= `RBMC_THIRD_FALL_RST;
    end else if (wr_en) begin
      if (addr == `RBMC_BURST_CFG_ADDR) begin
        burst_cfg <= wr_data;
      end
      if (addr == `RBMC_THIRD_FALL_ADDR) begin
        third_pwm_fall <= wr_data;
      end
    end
  end
  // ================================================================
  // Registered read, unmapped reads as zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      case (addr)
        `RBMC_BURST_CFG_ADDR: rd_data <= burst_cfg;
        `RBMC_THIRD_FALL_ADDR: rd_data <= third_pwm_fall;
        default: rd_data <= 8'h00;
      endcase
    end
  end
endmodule : rbmc_regfile
`default_nettype wire

/* File: testbench/rbmc_burst_ctrl_asserts.sv */
// Checker for the resonant burst-mode block, bound to its top module.
// Assumes only the top ports; keeps its own copy of the config byte.
`timescale 1ns/1ps
`default_nettype none
module rbmc_burst_ctrl_asserts (
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  // Status and gating outputs
  input wire logic resonant_mode,
  input wire logic soft_start,
  input wire logic converter_on,
  input wire logic [7:0] freq_limit_max,
  input wire logic burst_allowed,
  input wire logic burst_active,
  input wire logic [8:0] burst_threshold
);
  // ==========================================
  // Shadow of the config byte
  logic [7:0] cfg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) cfg <= 8'h00;
    else if (reg_wr && reg_addr == 8'h4a) cfg <= reg_wdata;
  end
  // Windows of five cycles (three in a_soft_block and a_mode_ignore) cover the two-flop reset release
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_off_codes: assert property ((!cfg[6])[*5] |-> !burst_allowed)
    else $error("burst allowed under a disabling code");
  a_soft_block: assert property ((cfg[7:6] == 2'h1 && soft_start)[*3]
    |-> !burst_allowed) else $error("burst allowed in soft start");
  a_soft_allow: assert property ((resonant_mode && converter_on
    && soft_start && cfg[7:6] == 2'h3)[*5] |-> burst_allowed)
    else $error("burst blocked in soft start");
  a_run_allow: assert property ((resonant_mode && converter_on
    && !soft_start && cfg[6])[*5] |-> burst_allowed)
    else $error("burst blocked in regulation");
  a_thresh_calc: assert property ((resonant_mode && $stable(cfg)
    && $stable(freq_limit_max))[*5] |-> burst_threshold ==
    {1'b0, freq_limit_max} - {3'h0, cfg[5:0]})
    else $error("threshold wrong");
  a_active_gate: assert property (burst_active |-> burst_allowed)
    else $error("active without permission");
  a_mode_ignore: assert property ((!resonant_mode)[*3] |-> !burst_allowed
    && !burst_active && burst_threshold == 9'h000)
    else $error("gating outside resonant mode");
endmodule : rbmc_burst_ctrl_asserts
bind rbmc_burst_ctrl rbmc_burst_ctrl_asserts u_asserts (.core_clk, .nrst,
  .reg_addr, .reg_wr, .reg_wdata, .resonant_mode, .soft_start,
  .converter_on, .freq_limit_max, .burst_allowed, .burst_active,
  .burst_threshold);
`default_nettype wire

/* File: testbench/resonant_burst_mode_control_test.sv */
// Self-checking bench for the resonant burst-mode block.
// Assumes the package, header and design compile first.
`timescale 1ns/1ps
`default_nettype none
module resonant_burst_mode_control_test;
  logic core_clk = 0, nrst = 0, reg_wr = 0, resonant_mode = 0;
  logic soft_start = 0, converter_on = 0, burst_allowed, burst_active;
  logic [7:0] reg_addr = 0, reg_wdata = 0, freq_limit_max = 0, d;
  logic [7:0] switch_freq = 0, reg_rdata, third_pwm_output_fall_dt;
  logic [8:0] burst_threshold, thr;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  rbmc_burst_ctrl DUT (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .resonant_mode, .soft_start, .converter_on,
    .freq_limit_max, .switch_freq, .burst_allowed, .burst_active,
    .burst_threshold, .third_pwm_output_fall_dt);
  // ==========================================
  // Helpers
  task automatic chk(logic [8:0] seen, logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (5) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic phase(logic on, logic s);
    @(posedge core_clk);
    converter_on <= on;
    soft_start <= s;
    settle();
  endtask : phase
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr <= 1;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    settle();
    chk(reg_rdata, exp);
  endtask : rd
  function automatic logic ea(logic [1:0] c, logic s);
    return c == 2'h3 || (c == 2'h1 && !s);
  endfunction : ea
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ==========================================
  // Tests
  initial begin
    void'($urandom(2));
    repeat (20) @(posedge core_clk);
    nrst <= 1;
    repeat (3) @(posedge core_clk);
    rd(8'h4a, 8'h00);
    rd(8'h4b, 8'h00);
    $display("reset values done");
    @(posedge core_clk);
    resonant_mode <= 1'h1;
    // Every code, in soft start and in regulation; offset 3f at i 3,
    // limit 00 with offset 01 at i 1 so the threshold wraps
    for (int i = 0; i < 8; i++) begin
      d = {i[1:0], i == 3 ? 6'h3f : i == 1 ? 6'h01 : 6'($urandom)};
      phase(1'h0, i[2]);
      wr(8'h4a, d);
      freq_limit_max <= i == 3 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
      switch_freq <= 8'($urandom);
      phase(1'h1, i[2]);
      thr = {1'h0, freq_limit_max} - {3'h0, d[5:0]};
      chk(burst_allowed, ea(d[7:6], i[2]));
      chk(burst_threshold, thr);
      chk(burst_active, ea(d[7:6], i[2]) && switch_freq >= thr);
      rd(8'h4a, d);
    end
    $display("code table done");
    // Soft start entered and left with the converter running, then the converter switched off and back on
    wr(8'h4a, {2'h1, d[5:0]});
    phase(1'h1, 1'h1);
    chk(burst_allowed, 1'h0);
    phase(1'h1, 1'h0);
    chk(burst_allowed, 1'h1);
    phase(1'h1, 1'h1);
    chk(burst_allowed, 1'h0);
    wr(8'h4a, {2'h3, d[5:0]});
    settle();
    chk(burst_allowed, 1'h1);
    phase(1'h0, 1'h1);
    chk(burst_allowed, 1'h0);
    chk(burst_active, 1'h0);
    phase(1'h1, 1'h0);
    chk(burst_allowed, 1'h1);
    $display("phase walk done");
    @(posedge core_clk);
    resonant_mode <= 1'h0;
    settle();
    chk(burst_allowed, 1'h0);
    chk(burst_active, 1'h0);
    chk(burst_threshold, 9'h000);
    wr(8'h33, 8'h5a);
    rd(8'h33, 8'h00);
    rd(8'h4a, d);
    wr(8'h4b, 8'ha7);
    rd(8'h4b, 8'ha7);
    chk(third_pwm_output_fall_dt, 8'ha7);
    $display("mode and map done");
    // Reset in mid-run clears both registers and the exported copy
    @(posedge core_clk);
    nrst <= 1'h0;
    settle();
    chk(third_pwm_output_fall_dt, 8'h00);
    chk(reg_rdata, 8'h00);
    @(posedge core_clk);
    nrst <= 1'h1;
    repeat (3) @(posedge core_clk);
    rd(8'h4b, 8'h00);
    rd(8'h4a, 8'h00);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule : resonant_burst_mode_control_test
`default_nettype wire
